/* inc/hss_pkg.sv */
// Notes on behaviour
// R1 - each output follows one chosen source: direct, timer, pwm generator or sync pin
// R2 - host writes switch configuration only while the device is in normal mode
// R3 - in stop or sleep the last configuration holds and writes are ignored; a fault release without recovery still clears control fields here
// R4 - entering restart or fail-safe forces every output off
// R5 - supply undervoltage switches off every output that is on
// R6 - undervoltage shutdown disable bit keeps outputs on during undervoltage
// R7 - after undervoltage, recovery bit set restores programmed state, else outputs stay off
// R8 - without undervoltage recovery the affected control fields clear when undervoltage ends
// R9 - undervoltage shows only in the undervoltage status bit
// R10 - supply overvoltage switches off outputs unless the applicable disable bit keeps them
// R11 - in normal mode a per-switch disable bit keeps that switch on in overvoltage
// R12 - in stop or sleep one shared disable bit keeps all switches on in overvoltage
// R13 - after overvoltage a switch restores only with its recovery bit, else fields clear
// R14 - overvoltage recovery selection is held per switch
// R15 - overvoltage shows only in the overvoltage status bit
package hss_pkg;
	// ************************************************
	// register map, byte addresses on apb
	// ************************************************
	localparam int          ADDR_W       = 8;
	localparam logic [7:0]  OFF_CTRL     = 8'h00;
	localparam logic [7:0]  OFF_PROT     = 8'h04;
	localparam logic [7:0]  OFF_STAT     = 8'h08;
	localparam logic [7:0]  OFF_MASK     = 8'h0c;
	localparam logic [7:0]  OFF_STATE    = 8'h10;
	// ************************************************
	// field positions and reset values
	// ************************************************
	localparam int          PROT_UV_DIS  = 0;
	localparam int          PROT_UV_REC  = 1;
	localparam int          PROT_OV_LP   = 2;
	localparam int          PROT_OVDIS_L = 8;
	localparam int          PROT_OVREC_L = 16;
	localparam int          STAT_UV      = 0;
	localparam int          STAT_OV      = 1;
	localparam int          STAT_W       = 2;
	localparam int          STATE_OUT_L  = 8;
	localparam logic [1:0]  STAT_RST     = 2'h0;
	localparam logic [1:0]  MASK_RST     = 2'h0;
	// ************************************************
	// source select codes of one switch field
	// ************************************************
	localparam int          SEL_W        = 4;
	localparam int          SRC_N        = 9;
	localparam logic [3:0]  SEL_OFF      = 4'h0;
	localparam logic [3:0]  SEL_ON       = 4'h1;
	localparam logic [3:0]  SEL_TIMER1   = 4'h2;
	localparam logic [3:0]  SEL_PWM1     = 4'h4;
	localparam logic [3:0]  SEL_SYNC     = 4'h8;
	// device operating modes
	typedef enum logic [2:0] {
		MODE_NORMAL   = 3'h0,
		MODE_STOP     = 3'h1,
		MODE_SLEEP    = 3'h2,
		MODE_RESTART  = 3'h3,
		MODE_FAILSAFE = 3'h4
	} hss_mode_t;
endpackage

/* inc/hss_ch_if.sv */
`timescale 1ns/1ps
// ************************************************
// per-switch link between supervisor and channel
// ************************************************
interface hss_ch_if;
	import hss_pkg::*;
	logic [SEL_W-1:0] sel;
	logic             ov_dis;
	logic             ov_rec;
	logic             drive;
	logic             clr;
	modport top (
		output sel,
		output ov_dis,
		output ov_rec,
		input  drive,
		input  clr
	);
	modport ch (
		input  sel,
		input  ov_dis,
		input  ov_rec,
		output drive,
		output clr
	);
endinterface

/* hdl/hss_sync2.sv */
`timescale 1ns/1ps
// ************************************************
// two-flop synchroniser for pin levels
// ************************************************
module hss_sync2 #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// levels
	input  wire logic [W-1:0] d,
	output      logic [W-1:0] q
);
	logic [W-1:0] meta_q;
	// first stage feeds only the second stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule

/* hdl/hss_switch_ch.sv */
`timescale 1ns/1ps
// ************************************************
// one high-side channel: source pick and fault gating
// ************************************************
module hss_switch_ch
	import hss_pkg::*;
(
	// clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// shared supply and mode state
	input  wire logic             uv,
	input  wire logic             ov,
	input  wire logic             uv_fall,
	input  wire logic             ov_fall,
	input  wire logic             uv_dis,
	input  wire logic             uv_rec,
	input  wire logic             ov_dis_lp,
	input  wire logic             normal,
	input  wire logic             lowpower,
	input  wire logic             force_off,
	input  wire logic [SRC_N-1:0] src,
	// per-switch link
	hss_ch_if.ch                  link
);
	logic uv_hit_q;
	logic ov_hit_q;
	logic raw;
	logic uv_shut;
	logic ov_shut;
	logic active;
	// unknown codes above the sync code drive nothing
	assign raw     = (link.sel < SEL_W'(SRC_N)) ? src[link.sel] : 1'b0; // R1
	assign active  = link.sel != SEL_OFF;
	assign uv_shut = uv & ~uv_dis; // R5 R6
	assign ov_shut = ov & (normal ? ~link.ov_dis : (lowpower ? ~ov_dis_lp : 1'b1)); // R10 R11 R12
	// a channel hit by a fault stays off until the fault releases
	assign link.drive = raw & ~uv_shut & ~ov_shut & ~uv_hit_q & ~ov_hit_q & ~force_off; // R4 R5
	// no recovery: ask the supervisor to clear this field on release
	assign link.clr = (uv_fall & uv_hit_q & ~uv_rec) | (ov_fall & ov_hit_q & ~link.ov_rec); // R8 R13
	// remember which fault switched this channel off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			uv_hit_q <= 1'b0;
			ov_hit_q <= 1'b0;
		end else begin
			uv_hit_q <= (uv_shut & active) | (uv_hit_q & ~uv_fall); // R7
			ov_hit_q <= (ov_shut & active) | (ov_hit_q & ~ov_fall); // R13 R14
		end
	end
endmodule

/* hdl/hss_top.sv */
`timescale 1ns/1ps
// ************************************************
// high-side switch supervisor, apb register slave
// ************************************************
module hss_top
	import hss_pkg::*;
#(
	parameter int NUM_SW = 4
) (
	// clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output      logic [31:0]       prdata,
	output      logic              pready,
	output      logic              pslverr,
	// device mode from the mode controller
	input  wire logic [2:0]        dev_mode,
	// supply comparators and sync pin, asynchronous
	input  wire logic              switch_supply_uv,
	input  wire logic              switch_supply_ov,
	input  wire logic              external_sync_input,
	// internal timer and pwm generator outputs
	input  wire logic [1:0]        timer_src,
	input  wire logic [3:0]        pwm_src,
	// outputs
	output      logic [NUM_SW-1:0] high_side_output,
	output      logic              irq
);
	localparam int CTRL_W = SEL_W * NUM_SW;

	// ************************************************
	// pin synchronisation and release detection
	// ************************************************
	logic [2:0] pin_s;
	logic       uv_s;
	logic       ov_s;
	logic       sync_s;
	logic       uv_prev_q;
	logic       ov_prev_q;
	logic       uv_fall;
	logic       ov_fall;

	hss_sync2 #(
		.W(3)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       ({external_sync_input, switch_supply_ov, switch_supply_uv}),
		.q       (pin_s)
	);

	// named views of the synchronised levels
	assign uv_s   = pin_s[0];
	assign ov_s   = pin_s[1];
	assign sync_s = pin_s[2];

	// previous levels, only to find the end of a fault
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			uv_prev_q <= 1'b0;
			ov_prev_q <= 1'b0;
		end else begin
			uv_prev_q <= uv_s;
			ov_prev_q <= ov_s;
		end
	end

	assign uv_fall = uv_prev_q & ~uv_s;
	assign ov_fall = ov_prev_q & ~ov_s;

	// ************************************************
	// mode decode
	// ************************************************
	hss_mode_t mode;
	logic      normal;
	logic      lowpower;
	logic      force_off;

	// mode comes from same-clock logic, no synchroniser needed
	assign mode      = hss_mode_t'(dev_mode);
	assign normal    = mode == MODE_NORMAL;
	assign lowpower  = (mode == MODE_STOP) || (mode == MODE_SLEEP);
	assign force_off = (mode == MODE_RESTART) || (mode == MODE_FAILSAFE); // R4

	// ************************************************
	// apb decode
	// ************************************************
	logic access;
	logic wr;
	logic hit_ctrl;
	logic hit_prot;
	logic hit_stat;
	logic hit_mask;
	logic hit_state;
	logic hit_any;
	logic cfg_wr_ok;

	assign access    = psel & penable;
	assign wr        = access & pwrite;
	assign hit_ctrl  = paddr == OFF_CTRL;
	assign hit_prot  = paddr == OFF_PROT;
	assign hit_stat  = paddr == OFF_STAT;
	assign hit_mask  = paddr == OFF_MASK;
	assign hit_state = paddr == OFF_STATE;
	assign hit_any   = hit_ctrl | hit_prot | hit_stat | hit_mask | hit_state;
	// configuration is frozen outside normal mode except for fault-release clears; such writes finish but store nothing
	assign cfg_wr_ok = wr & normal; // R2 R3

	// zero wait states; an unmapped address answers with an error
	assign pready  = 1'b1;
	assign pslverr = access & ~hit_any;

	// ************************************************
	// configuration registers
	// ************************************************
	logic [CTRL_W-1:0] ctrl_q;
	logic [CTRL_W-1:0] ctrl_d;
	logic              uv_dis_q;
	logic              uv_rec_q;
	logic              ov_lp_q;
	logic [NUM_SW-1:0] ov_dis_q;
	logic [NUM_SW-1:0] ov_rec_q;
	logic [NUM_SW-1:0] clr_v;
	logic [NUM_SW-1:0] drive_v;
	logic [SRC_N-1:0]  src;

	// source table in select-code order: off, on, timers, pwm, sync
	assign src = {sync_s, pwm_src, timer_src, 1'b1, 1'b0}; // R1

	// protection bits live beside the source fields and freeze the same way
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			uv_dis_q <= 1'b0;
			uv_rec_q <= 1'b0;
			ov_lp_q  <= 1'b0;
			ov_dis_q <= '0;
			ov_rec_q <= '0;
		end else if (cfg_wr_ok && hit_prot) begin // R3
			uv_dis_q <= pwdata[PROT_UV_DIS]; // R6
			uv_rec_q <= pwdata[PROT_UV_REC]; // R7
			ov_lp_q  <= pwdata[PROT_OV_LP]; // R12
			ov_dis_q <= pwdata[PROT_OVDIS_L +: NUM_SW]; // R11
			ov_rec_q <= pwdata[PROT_OVREC_L +: NUM_SW]; // R14
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= '0;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// ************************************************
	// channels
	// ************************************************
	hss_ch_if chif [NUM_SW] ();

	genvar gi;
	generate
		for (gi = 0; gi < NUM_SW; gi++) begin : g_ch
			// a fault-release clear beats a concurrent host write
			assign ctrl_d[gi*SEL_W +: SEL_W] = clr_v[gi] ? SEL_OFF : // R8 R13
				((cfg_wr_ok && hit_ctrl) ? pwdata[gi*SEL_W +: SEL_W] : // R3
				ctrl_q[gi*SEL_W +: SEL_W]);
			assign chif[gi].sel    = ctrl_q[gi*SEL_W +: SEL_W];
			assign chif[gi].ov_dis = ov_dis_q[gi];
			assign chif[gi].ov_rec = ov_rec_q[gi]; // R14
			assign clr_v[gi]       = chif[gi].clr;
			assign drive_v[gi]     = chif[gi].drive;

			hss_switch_ch u_ch (
				.pclk      (pclk),
				.presetn   (presetn),
				.uv        (uv_s),
				.ov        (ov_s),
				.uv_fall   (uv_fall),
				.ov_fall   (ov_fall),
				.uv_dis    (uv_dis_q),
				.uv_rec    (uv_rec_q),
				.ov_dis_lp (ov_lp_q),
				.normal    (normal),
				.lowpower  (lowpower),
				.force_off (force_off),
				.src       (src),
				.link      (chif[gi])
			);
		end
	endgenerate

	// outputs are registered so a glitchy source select never reaches the pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			high_side_output <= '0;
		end else begin
			high_side_output <= drive_v; // R4 R5 R10
		end
	end

	// ************************************************
	// status, mask and interrupt
	// ************************************************
	logic [STAT_W-1:0] stat_q;
	logic [STAT_W-1:0] mask_q;
	logic [STAT_W-1:0] stat_set;
	logic [STAT_W-1:0] stat_clr;

	// each supply fault owns one bit and touches no other flag
	assign stat_set = {ov_s, uv_s}; // R9 R15
	assign stat_clr = (wr && hit_stat) ? pwdata[STAT_W-1:0] : '0;

	// set wins over a write-one clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_q <= STAT_RST;
		end else begin
			stat_q <= (stat_q & ~stat_clr) | stat_set; // R9 R15
		end
	end

	// mask is not part of switch configuration, so it stays writable in every mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_q <= MASK_RST;
		end else if (wr && hit_mask) begin
			mask_q <= pwdata[STAT_W-1:0];
		end
	end

	assign irq = |(stat_q & mask_q);

	// ************************************************
	// read data
	// ************************************************
	logic [31:0] rd_val;

	always_comb begin
		rd_val = '0;
		if (hit_ctrl) begin
			rd_val[CTRL_W-1:0] = ctrl_q;
		end else if (hit_prot) begin
			rd_val[PROT_UV_DIS]          = uv_dis_q;
			rd_val[PROT_UV_REC]          = uv_rec_q;
			rd_val[PROT_OV_LP]           = ov_lp_q;
			rd_val[PROT_OVDIS_L +: NUM_SW] = ov_dis_q;
			rd_val[PROT_OVREC_L +: NUM_SW] = ov_rec_q;
		end else if (hit_stat) begin
			rd_val[STAT_W-1:0] = stat_q;
		end else if (hit_mask) begin
			rd_val[STAT_W-1:0] = mask_q;
		end else if (hit_state) begin
			rd_val[2:0]                   = dev_mode;
			rd_val[STATE_OUT_L +: NUM_SW] = high_side_output;
		end
	end

	// captured in the setup cycle, stable through the access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (psel && !penable && !pwrite) begin
			prdata <= rd_val;
		end
	end

	// ************************************************
	// checks
	// ************************************************
	force_off_a: assert property (@(posedge pclk) disable iff (!presetn) // R4
		force_off |=> high_side_output == '0)
		else $error("output on in restart or fail-safe");

	cfg_freeze_a: assert property (@(posedge pclk) disable iff (!presetn) // R3
		(!normal && wr && (hit_ctrl || hit_prot) && clr_v == '0)
		|=> $stable(ctrl_q) && $stable(ov_dis_q) && $stable(uv_rec_q))
		else $error("configuration changed outside normal mode");

	uv_off_a: assert property (@(posedge pclk) disable iff (!presetn) // R5
		(uv_s && !uv_dis_q) |=> high_side_output == '0)
		else $error("output on during undervoltage");

	uv_keep_a: assert property (@(posedge pclk) disable iff (!presetn) // R6
		(uv_s && uv_dis_q && !ov_s && normal && high_side_output[0]
		&& ctrl_q[SEL_W-1:0] == SEL_ON && $stable(ctrl_q)) |=> high_side_output[0])
		else $error("undervoltage switched off with shutdown disabled");

	fault_clr_a: assert property (@(posedge pclk) disable iff (!presetn) // R8 R13
		clr_v[0] |=> ctrl_q[SEL_W-1:0] == SEL_OFF)
		else $error("control field not cleared after fault");

	recover_keep_a: assert property (@(posedge pclk) disable iff (!presetn) // R7 R13 R14
		((uv_fall && uv_rec_q && !ov_fall) || (ov_fall && ov_rec_q[1] && !uv_fall))
		|-> !clr_v[1])
		else $error("field cleared although recovery enabled");

	uv_flag_a: assert property (@(posedge pclk) disable iff (!presetn) // R9
		$rose(uv_s) ##1 !ov_s |=> stat_q[STAT_UV])
		else $error("undervoltage flag not set");

	ov_flag_a: assert property (@(posedge pclk) disable iff (!presetn) // R15
		ov_s |=> stat_q[STAT_OV])
		else $error("overvoltage flag not set");

	ov_normal_a: assert property (@(posedge pclk) disable iff (!presetn) // R10 R11
		(ov_s && normal) |=> (high_side_output & ~$past(ov_dis_q)) == '0)
		else $error("output on in overvoltage without disable");

	ov_lowpwr_a: assert property (@(posedge pclk) disable iff (!presetn) // R12
		(ov_s && lowpower && !ov_lp_q) |=> high_side_output == '0)
		else $error("output on in low-power overvoltage");

	apb_err_a: assert property (@(posedge pclk) disable iff (!presetn)
		(access && !hit_any) |-> pslverr && pready)
		else $error("unmapped access not flagged");

	ov_cause_a: assert property (@(posedge pclk) disable iff (!presetn) // R15
		$rose(stat_q[STAT_OV]) |-> $past(ov_s))
		else $error("overvoltage flag set without overvoltage");

	uv_cause_a: assert property (@(posedge pclk) disable iff (!presetn) // R9
		$rose(stat_q[STAT_UV]) |-> $past(uv_s))
		else $error("undervoltage flag set without undervoltage");

	uv_sticky_a: assert property (@(posedge pclk) disable iff (!presetn) // R9
		(stat_q[STAT_UV] && !(wr && hit_stat && pwdata[STAT_UV])) |=> stat_q[STAT_UV])
		else $error("undervoltage flag lost without clear");

	ov_sticky_a: assert property (@(posedge pclk) disable iff (!presetn) // R15
		(stat_q[STAT_OV] && !(wr && hit_stat && pwdata[STAT_OV])) |=> stat_q[STAT_OV])
		else $error("overvoltage flag lost without clear");

	prot_freeze_a: assert property (@(posedge pclk) disable iff (!presetn) // R3
		!normal |=> $stable(uv_dis_q) && $stable(uv_rec_q) && $stable(ov_lp_q)
		&& $stable(ov_dis_q) && $stable(ov_rec_q))
		else $error("protection bits changed outside normal mode");

	clr_only_a: assert property (@(posedge pclk) disable iff (!presetn) // R8 R13
		!(uv_fall || ov_fall) |-> clr_v == '0)
		else $error("control field cleared without fault release");
endmodule

/* tb/hss_host.sv */
`timescale 1ns/1ps
// ************************************************
// host model: apb master in front of the supervisor
// ************************************************
module hss_host
	import hss_pkg::*;
(
	// clock
	input  wire logic              pclk,
	// apb master side
	output      logic              psel,
	output      logic              penable,
	output      logic              pwrite,
	output      logic [ADDR_W-1:0] paddr,
	output      logic [31:0]       pwdata,
	input  wire logic [31:0]       prdata,
	input  wire logic              pready,
	input  wire logic              pslverr
);
	// idle bus at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
	end

	// one transfer; request held until pready is seen high, bounded wait
	task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err, output logic ok);
		int n;
		n = 0;
		ok = 1'b0;
		q = '0;
		err = 1'b0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		while (!ok && n < 16) begin
			@(posedge pclk);
			n++;
			if (pready === 1'b1) begin
				ok = 1'b1;
				q = prdata;
				err = pslverr;
			end
		end
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d; // released data no longer shows the last value
	endtask
endmodule

/* tb/tb.sv */
`timescale 1ns/1ps
// ************************************************
// supervisor testbench
// ************************************************
module tb;
	import hss_pkg::*;
	logic              pclk;
	logic              presetn;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic [2:0]        dev_mode;
	logic              uv;
	logic              ov;
	logic              sync_pin;
	logic [1:0]        timer_src;
	logic [3:0]        pwm_src;
	logic [3:0]        hso;
	logic              irq;
	int                error_cnt;
	int                comparisons;
	logic [31:0]       q;
	logic              err;
	logic [6:0]        oh;
	logic              ex;

	hss_top #(.NUM_SW(4)) hss_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .dev_mode(dev_mode), .switch_supply_uv(uv),
		.switch_supply_ov(ov), .external_sync_input(sync_pin), .timer_src(timer_src),
		.pwm_src(pwm_src), .high_side_output(hso), .irq(irq));
	hss_host hss_host_i (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	// clock, 10 ns period
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// verdict, the only place the run ends
	task automatic close_out();
		if (error_cnt == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// bus access; a hung bus ends the run
	task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		logic ok;
		hss_host_i.xfer(w, a, d, q, err, ok);
		if (!ok) begin
			error_cnt++;
			close_out();
		end
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		acc(1'b1, a, d);
	endtask

	task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
		acc(1'b0, a, 32'h0);
		chk(q, exp);
	endtask

	// pins take three edges to reach outputs and flags, one more when a fault releases
	task automatic settle(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task automatic outs(input logic [3:0] exp);
		chk({28'h0, hso}, {28'h0, exp});
	endtask

	initial begin
		presetn = 1'b0;
		dev_mode = MODE_NORMAL;
		uv = 1'b0;
		ov = 1'b0;
		{sync_pin, pwm_src, timer_src} = 7'h00;
		error_cnt = 0;
		comparisons = 0;
		settle(16);
		presetn <= 1'b1;
		// reset values of every register, unmapped and read-only places
		rdc(OFF_CTRL, 32'h0);
		rdc(OFF_PROT, 32'h0);
		rdc(OFF_STAT, {30'h0, STAT_RST});
		rdc(OFF_MASK, {30'h0, MASK_RST});
		rdc(OFF_STATE, 32'h0);
		rdc(8'h14, 32'h0);
		chk({31'h0, err}, 32'h1);
		wr(OFF_STATE, 32'hffffffff);
		rdc(OFF_STATE, 32'h0);
		// every source code on switch 0, chosen source high then low
		for (int c = 0; c < 10; c++) begin
			wr(OFF_CTRL, 32'(c));
			for (int p = 0; p < 2; p++) begin
				oh = (c >= 2 && c <= 8) ? 7'(1 << (c - 2)) : 7'h00;
				{sync_pin, pwm_src, timer_src} <= p ? ~oh : oh;
				settle(4);
				ex = (c == 1) || (c >= 2 && c <= 8 && p == 0);
				chk({31'h0, hso[0]}, {31'h0, ex});
			end
		end
		{sync_pin, pwm_src, timer_src} <= 7'h00;
		// low-power modes freeze configuration, mask stays writable
		wr(OFF_CTRL, 32'h11);
		wr(OFF_PROT, 32'h0);
		settle(3);
		rdc(OFF_STATE, 32'h300);
		for (int m = 1; m < 3; m++) begin
			dev_mode <= 3'(m);
			settle(2);
			wr(OFF_CTRL, 32'h0);
			wr(OFF_PROT, 32'h4);
			wr(OFF_MASK, 32'(m));
			rdc(OFF_CTRL, 32'h11);
			rdc(OFF_PROT, 32'h0);
			rdc(OFF_MASK, 32'(m));
			outs(4'h3);
		end
		// restart and fail-safe force outputs off
		for (int m = 3; m < 5; m++) begin
			dev_mode <= MODE_NORMAL;
			settle(2);
			wr(OFF_CTRL, 32'h11);
			settle(3);
			outs(4'h3);
			dev_mode <= 3'(m);
			settle(2);
			outs(4'h0);
			rdc(OFF_STATE, 32'(m));
		end
		dev_mode <= MODE_NORMAL;
		settle(2);
		// undervoltage without recovery, flag, mask and clear
		wr(OFF_MASK, 32'h3);
		wr(OFF_CTRL, 32'h2101);
		timer_src <= 2'b01;
		settle(4);
		outs(4'hd);
		uv <= 1'b1;
		settle(4);
		outs(4'h0);
		rdc(OFF_STAT, 32'h1);
		chk({31'h0, irq}, 32'h1);
		wr(OFF_MASK, 32'h0);
		settle(1);
		chk({31'h0, irq}, 32'h0);
		wr(OFF_MASK, 32'h3);
		uv <= 1'b0;
		settle(4);
		outs(4'h0);
		rdc(OFF_CTRL, 32'h0);
		wr(OFF_STAT, 32'h3);
		settle(1);
		chk({31'h0, irq}, 32'h0);
		rdc(OFF_STAT, 32'h0);
		// undervoltage with recovery, then with shutdown disabled
		for (int k = 0; k < 2; k++) begin
			wr(OFF_PROT, k ? 32'h1 : 32'h2);
			wr(OFF_CTRL, 32'h1);
			uv <= 1'b1;
			settle(4);
			outs(k ? 4'h1 : 4'h0);
			rdc(OFF_STAT, 32'h1);
			uv <= 1'b0;
			settle(5);
			outs(4'h1);
			rdc(OFF_CTRL, 32'h1);
			wr(OFF_STAT, 32'h3);
		end
		// overvoltage in normal mode, per-switch disable and recovery
		wr(OFF_PROT, 32'h20100);
		wr(OFF_CTRL, 32'h1111);
		settle(3);
		outs(4'hf);
		ov <= 1'b1;
		settle(4);
		outs(4'h1);
		rdc(OFF_STAT, 32'h2);
		ov <= 1'b0;
		settle(5);
		outs(4'h3);
		rdc(OFF_CTRL, 32'h11);
		wr(OFF_STAT, 32'h3);
		// overvoltage in low power: shared disable on, then off
		for (int k = 0; k < 2; k++) begin
			wr(OFF_PROT, k ? 32'h100 : 32'h4);
			wr(OFF_CTRL, 32'h1111);
			settle(3);
			dev_mode <= k ? MODE_SLEEP : MODE_STOP;
			settle(2);
			ov <= 1'b1;
			settle(4);
			outs(k ? 4'h0 : 4'hf);
			ov <= 1'b0;
			settle(4);
			rdc(OFF_CTRL, k ? 32'h0 : 32'h1111);
			dev_mode <= MODE_NORMAL;
			wr(OFF_STAT, 32'h3);
		end
		rdc(OFF_STAT, 32'h0);
		close_out();
	end
endmodule
